// >>> stp_regs.svh
// register offsets, field positions, codes and timing for the self-test command block
// assumes a 12-bit apb byte address and a 50 ns pclk
`ifndef STP_REGS_SVH
`define STP_REGS_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define STP_OFF_CMD 12'h000
`define STP_OFF_CPL 12'h004
`define STP_OFF_LOG 12'h008
`define STP_OFF_OPT 12'h00C
`define STP_OFF_INT_ST 12'h010
`define STP_OFF_INT_MASK 12'h014
`define STP_OFF_STATE 12'h018

// ************************************************************
// field positions
// ************************************************************
`define STP_STC_MSB 3
`define STP_STC_LSB 0
`define STP_CPL_SC_LSB 0
`define STP_CPL_SCT_LSB 8
`define STP_CPL_POSTED_BIT 16
`define STP_LOG_CUR_LSB 0
`define STP_LOG_RES_LSB 8
`define STP_LOG_RES_STC_LSB 12
`define STP_OPT_BIT 0
`define STP_INT_CPL_BIT 0
`define STP_INT_DONE_BIT 1
`define STP_STATE_BUSY_BIT 0
`define STP_STATE_RUN_BIT 1
`define STP_STATE_SUBSYS_BIT 2

// ************************************************************
// codes
// ************************************************************
`define STP_STC_SHORT 4'h1
`define STP_STC_EXT 4'h2
`define STP_STC_VENDOR 4'hE
`define STP_STC_ABORT 4'hF
`define STP_SC_SUCCESS 8'h00
`define STP_SC_INVALID_FIELD 8'h02
`define STP_SC_IN_PROGRESS 8'h1D
`define STP_SCT_GENERIC 3'h0
`define STP_SCT_CMD 3'h1
`define STP_CUR_IDLE 4'h0
`define STP_RES_PASS 4'h0
`define STP_RES_ABORTED 4'h1

// ************************************************************
// reset values and timing
// ************************************************************
`define STP_OPT_RST 1'h0
`define STP_MASK_RST 2'h0
`define STP_CLK_NS 50
`define STP_SHORT_US 1000
`define STP_EXT_US 10000

`endif

// >>> stp_pkg.sv
// types shared by the self-test command block and its test engine
// assumes stp_regs.svh for all numeric constants
package stp_pkg;

  typedef enum logic [3:0] {
    st_idle,
    st_decode,
    st_validate,
    st_set_stat,
    st_start,
    st_abort_stop,
    st_abort_log,
    st_abort_stat,
    st_post
  } stp_fsm_t;

  typedef struct packed {
    stp_fsm_t fsm;
    logic [31:0] dw10;
    logic [7:0] sc;
    logic [2:0] sct;
    logic cpl_posted;
    logic [3:0] cur_status;
    logic [3:0] new_result;
    logic [3:0] new_stc;
    logic opt0;
    logic [1:0] int_st;
    logic [1:0] int_mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic cpl_post;
    logic busy_s1;
    logic busy_s2;
    logic eng_start;
    logic eng_ext;
    logic eng_abort;
  } stp_top_state_t;

  typedef struct packed {
    logic running;
    logic done;
    logic [31:0] cnt;
    logic [31:0] limit;
  } stp_eng_state_t;

endpackage

// >>> stp_eng_if.sv
// control link between the command sequencer and the test engine
// assumes both ends run on the same pclk
`timescale 1ns/1ps
interface stp_eng_if;
  logic start;
  logic ext;
  logic abort;
  logic running;
  logic done;

  modport ctl
  (
    output start,
    output ext,
    output abort,
    input running,
    input done
  );

  modport eng
  (
    input start,
    input ext,
    input abort,
    output running,
    output done
  );
endinterface

// >>> stp_test_engine.sv
// self-test engine: runs a short or extended test for a fixed cycle count
// assumes start and abort are one-cycle pulses from the sequencer
`timescale 1ns/1ps
module stp_test_engine
#(
  parameter int unsigned SHORT_CYCLES = 20000,
  parameter int unsigned EXT_CYCLES = 200000
)
(
  input wire logic pclk,
  input wire logic presetn,
  stp_eng_if.eng eng
);

  stp_pkg::stp_eng_state_t r;
  stp_pkg::stp_eng_state_t n;

  if (SHORT_CYCLES < 1 || EXT_CYCLES < 1)
  begin : g_bad_len
    $error("test lengths must be at least one cycle");
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    n = r;
    n.done = 1'b0;
    if (r.running && eng.abort)
    begin
      // abort beats a finish in the same cycle: no pass entry
      n.running = 1'b0;
    end
    else if (r.running)
    begin
      if (r.cnt == r.limit)
      begin
        n.running = 1'b0;
        n.done = 1'b1;
      end
      else
      begin
        n.cnt = r.cnt + 32'h00000001;
      end
    end
    else if (eng.start)
    begin
      n.running = 1'b1;
      n.cnt = 32'h00000001;
      n.limit = eng.ext ? 32'(EXT_CYCLES) : 32'(SHORT_CYCLES);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  assign eng.running = r.running;
  assign eng.done = r.done;

endmodule

// >>> stp_self_test_cmd.sv
// self-test admin command sequencer with apb register access
// assumes an apb master on pclk and a pin that flags a test elsewhere in the subsystem
//
// Summary of operation
// (R1) test running and short or extended requested: reject with in-progress status
// (R2) in-progress status code value is 1Dh
// (R3) abort honoured if option bit 0 clear, or set and test runs here
// (R4) honoured abort: stop test, write newest result, status 0h, complete successfully
// (R5) idle short request: validate, status 1h, start test, complete successfully
// (R6) idle extended request: validate, status 2h, start test, complete successfully
// (R7) idle abort request completes successfully and leaves the log unchanged
// (R8) vendor code completes successfully with no test action
// (R9) option bit 0 clear: judge running locally; set: judge across subsystem
// (R10) completion posted only after all actions of the case are done
// (R11) test code sits in dword 10 bits 3:0; 0h and 3h-Dh reserved
// (R12) reserved test code rejected as invalid field, log unchanged
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "stp_regs.svh"
module stp_self_test_cmd
#(
  parameter int unsigned SHORT_CYCLES = (`STP_SHORT_US * 1000) / `STP_CLK_NS,
  parameter int unsigned EXT_CYCLES = (`STP_EXT_US * 1000) / `STP_CLK_NS
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic cpl_post,
  input wire logic subsys_busy_pin
);

  stp_pkg::stp_top_state_t r;
  stp_pkg::stp_top_state_t n;
  logic setup;
  logic wr_acc;
  logic in_prog;
  logic [1:0] int_set;
  logic [1:0] int_clr;
  logic [3:0] self_test_code;

  stp_eng_if eng ();

  stp_test_engine #(
    .SHORT_CYCLES(SHORT_CYCLES),
    .EXT_CYCLES(EXT_CYCLES)
  ) u_engine (
    .pclk(pclk),
    .presetn(presetn),
    .eng(eng)
  );

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [3:0] stc_of(input logic [31:0] dw10);
    stc_of = dw10[`STP_STC_MSB:`STP_STC_LSB]; // see (R11)
  endfunction

  function automatic logic stc_reserved(input logic [3:0] code);
    stc_reserved = !(code == `STP_STC_SHORT || code == `STP_STC_EXT ||
                     code == `STP_STC_VENDOR || code == `STP_STC_ABORT); // see (R11)
  endfunction

  assign setup = psel && !penable && !r.pready;
  assign wr_acc = psel && penable && r.pready && pwrite && !r.pslverr;
  assign self_test_code = stc_of(r.dw10);
  // local engine only, or any controller when option bit 0 is set
  assign in_prog = eng.running || (r.opt0 && r.busy_s2); // see (R9)

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    n = r;
    int_set = 2'h0;
    int_clr = 2'h0;
    n.busy_s1 = subsys_busy_pin;
    n.busy_s2 = r.busy_s1;
    n.eng_start = 1'b0;
    n.eng_abort = 1'b0;
    n.cpl_post = 1'b0;
    n.pready = setup;

    // apb setup: prepare answer for the access cycle
    if (setup)
    begin
      n.pslverr = 1'b0;
      n.prdata = 32'h00000000;
      case (paddr)
        `STP_OFF_CMD:
        begin
          n.prdata = r.dw10;
          n.pslverr = pwrite && (r.fsm != stp_pkg::st_idle);
        end
        `STP_OFF_CPL:
        begin
          n.prdata[`STP_CPL_SC_LSB +: 8] = r.sc;
          n.prdata[`STP_CPL_SCT_LSB +: 3] = r.sct;
          n.prdata[`STP_CPL_POSTED_BIT] = r.cpl_posted;
        end
        `STP_OFF_LOG:
        begin
          n.prdata[`STP_LOG_CUR_LSB +: 4] = r.cur_status;
          n.prdata[`STP_LOG_RES_LSB +: 4] = r.new_result;
          n.prdata[`STP_LOG_RES_STC_LSB +: 4] = r.new_stc;
        end
        `STP_OFF_OPT: n.prdata[`STP_OPT_BIT] = r.opt0;
        `STP_OFF_INT_ST: n.prdata[1:0] = r.int_st;
        `STP_OFF_INT_MASK: n.prdata[1:0] = r.int_mask;
        `STP_OFF_STATE:
        begin
          n.prdata[`STP_STATE_BUSY_BIT] = (r.fsm != stp_pkg::st_idle);
          n.prdata[`STP_STATE_RUN_BIT] = eng.running;
          n.prdata[`STP_STATE_SUBSYS_BIT] = r.busy_s2;
        end
        default: n.pslverr = 1'b1;
      endcase
    end
    else if (r.pready)
    begin
      n.pslverr = 1'b0;
      n.prdata = 32'h00000000;
    end

    // natural end of a test
    if (eng.done)
    begin
      n.new_result = `STP_RES_PASS;
      n.new_stc = r.cur_status;
      n.cur_status = `STP_CUR_IDLE;
      int_set[`STP_INT_DONE_BIT] = 1'b1;
    end

    // ************************************************************
    // command sequencer
    // ************************************************************
    case (r.fsm)
      stp_pkg::st_idle:
      begin
        n.fsm = stp_pkg::st_idle;
      end
      stp_pkg::st_decode:
      begin
        n.fsm = stp_pkg::st_post;
        n.sc = `STP_SC_SUCCESS;
        n.sct = `STP_SCT_GENERIC;
        case (self_test_code)
          `STP_STC_SHORT, `STP_STC_EXT:
          begin
            if (in_prog)
            begin
              n.sc = `STP_SC_IN_PROGRESS; // see (R1) see (R2)
              n.sct = `STP_SCT_CMD;
            end
            else
            begin
              n.fsm = stp_pkg::st_validate; // see (R5) see (R6)
            end
          end
          `STP_STC_VENDOR:
          begin
            n.fsm = stp_pkg::st_post; // see (R8)
          end
          `STP_STC_ABORT:
          begin
            // with bit 0 set, a test on another controller is not ours to stop
            if (in_prog && (!r.opt0 || eng.running))
            begin
              n.fsm = stp_pkg::st_abort_stop; // see (R3)
            end
            else
            begin
              n.fsm = stp_pkg::st_post; // see (R7)
            end
          end
          default:
          begin
            n.sc = `STP_SC_INVALID_FIELD; // see (R12)
          end
        endcase
      end
      stp_pkg::st_validate:
      begin
        // only the test code carries parameters here
        n.fsm = stp_pkg::st_set_stat;
      end
      stp_pkg::st_set_stat:
      begin
        n.cur_status = self_test_code; // see (R5) see (R6)
        n.fsm = stp_pkg::st_start;
      end
      stp_pkg::st_start:
      begin
        n.eng_start = 1'b1;
        n.eng_ext = (self_test_code == `STP_STC_EXT);
        n.fsm = stp_pkg::st_post;
      end
      stp_pkg::st_abort_stop:
      begin
        n.eng_abort = 1'b1; // see (R4)
        n.fsm = stp_pkg::st_abort_log;
      end
      stp_pkg::st_abort_log:
      begin
        n.new_result = `STP_RES_ABORTED; // see (R4)
        n.new_stc = r.cur_status;
        n.fsm = stp_pkg::st_abort_stat;
      end
      stp_pkg::st_abort_stat:
      begin
        n.cur_status = `STP_CUR_IDLE; // see (R4)
        n.fsm = stp_pkg::st_post;
      end
      stp_pkg::st_post:
      begin
        n.cpl_post = 1'b1; // see (R10)
        n.cpl_posted = 1'b1;
        int_set[`STP_INT_CPL_BIT] = 1'b1;
        n.fsm = stp_pkg::st_idle;
      end
      default:
      begin
        n.fsm = stp_pkg::st_idle;
      end
    endcase

    // apb writes take effect at the access edge
    if (wr_acc)
    begin
      case (paddr)
        `STP_OFF_CMD:
        begin
          n.dw10 = pwdata;
          n.cpl_posted = 1'b0;
          n.fsm = stp_pkg::st_decode;
        end
        `STP_OFF_OPT: n.opt0 = pwdata[`STP_OPT_BIT];
        `STP_OFF_INT_ST: int_clr = pwdata[1:0];
        `STP_OFF_INT_MASK: n.int_mask = pwdata[1:0];
        default: n.opt0 = r.opt0;
      endcase
    end

    // set wins over a clear in the same cycle
    n.int_st = (r.int_st & ~int_clr) | int_set;
    n.irq = |(n.int_st & n.int_mask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= '0;
      r.fsm <= stp_pkg::st_idle;
      r.opt0 <= `STP_OPT_RST;
      r.int_mask <= `STP_MASK_RST;
      r.cur_status <= `STP_CUR_IDLE;
    end
    else
    begin
      r <= n;
    end
  end

  assign eng.start = r.eng_start;
  assign eng.ext = r.eng_ext;
  assign eng.abort = r.eng_abort;
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign irq = r.irq;
  assign cpl_post = r.cpl_post;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_abort_steps;
    (r.fsm == stp_pkg::st_abort_stop) ##1 (r.fsm == stp_pkg::st_abort_log && r.eng_abort)
      ##1 (r.fsm == stp_pkg::st_abort_stat && r.new_result == `STP_RES_ABORTED)
      ##1 (r.fsm == stp_pkg::st_post && r.cur_status == `STP_CUR_IDLE);
  endsequence

  sequence s_start_steps(logic [3:0] code);
    (r.fsm == stp_pkg::st_validate) ##1 (r.fsm == stp_pkg::st_set_stat)
      ##1 (r.fsm == stp_pkg::st_start && r.cur_status == code)
      ##1 (r.fsm == stp_pkg::st_post && r.eng_start);
  endsequence

  AST_INPROG_REJECT: assert property ( // see (R1)
    (r.fsm == stp_pkg::st_decode && (self_test_code == `STP_STC_SHORT || self_test_code == `STP_STC_EXT) && in_prog)
      |=> (r.fsm == stp_pkg::st_post && r.sct == `STP_SCT_CMD && !r.eng_start)
      ##1 (cpl_post && r.sc == `STP_SC_IN_PROGRESS && r.fsm == stp_pkg::st_idle))
    else $error("busy start request not rejected");
  AST_SC_VALUE: assert property ( // see (R2)
    (cpl_post && r.sct == `STP_SCT_CMD) |-> r.sc == `STP_SC_IN_PROGRESS)
    else $error("in-progress status code wrong");
  AST_ABORT_HONOUR: assert property ( // see (R3)
    (r.fsm == stp_pkg::st_decode && self_test_code == `STP_STC_ABORT && eng.running)
      |=> r.fsm == stp_pkg::st_abort_stop)
    else $error("abort of local test not honoured");
  AST_ABORT_ORDER: assert property ( // see (R4)
    (r.fsm == stp_pkg::st_abort_stop) |-> s_abort_steps ##1 (cpl_post && !eng.running))
    else $error("abort steps out of order");
  AST_SHORT_ORDER: assert property ( // see (R5)
    (r.fsm == stp_pkg::st_decode && self_test_code == `STP_STC_SHORT && !in_prog)
      |=> s_start_steps(`STP_STC_SHORT) ##1 cpl_post ##1 eng.running)
    else $error("short test steps out of order");
  AST_EXT_ORDER: assert property ( // see (R6)
    (r.fsm == stp_pkg::st_decode && self_test_code == `STP_STC_EXT && !in_prog)
      |=> s_start_steps(`STP_STC_EXT) ##1 cpl_post ##1 eng.running)
    else $error("extended test steps out of order");
  AST_IDLE_ABORT: assert property ( // see (R7)
    (r.fsm == stp_pkg::st_decode && self_test_code == `STP_STC_ABORT && !in_prog && !eng.done)
      |=> r.fsm == stp_pkg::st_post && r.sc == `STP_SC_SUCCESS && $stable(r.cur_status)
          && $stable(r.new_result) && $stable(r.new_stc))
    else $error("idle abort touched the log");
  AST_VENDOR: assert property ( // see (R8)
    (r.fsm == stp_pkg::st_decode && self_test_code == `STP_STC_VENDOR) |=> ##1 (cpl_post && r.sc == `STP_SC_SUCCESS))
    else $error("vendor code not completed");
  AST_SUBSYS_BUSY: assert property ( // see (R9)
    (r.fsm == stp_pkg::st_decode && self_test_code == `STP_STC_SHORT && r.opt0 && r.busy_s2)
      |=> r.sc == `STP_SC_IN_PROGRESS)
    else $error("subsystem test not seen as in progress");
  AST_POST_LAST: assert property ( // see (R10)
    cpl_post |-> $past(r.fsm) == stp_pkg::st_post && r.fsm == stp_pkg::st_idle && r.int_st[`STP_INT_CPL_BIT])
    else $error("completion posted out of place");
  AST_RESERVED: assert property ( // see (R12)
    (r.fsm == stp_pkg::st_decode && stc_reserved(self_test_code) && !eng.done)
      |=> (r.sc == `STP_SC_INVALID_FIELD && r.sct == `STP_SCT_GENERIC && $stable(r.cur_status)) ##1 cpl_post)
    else $error("reserved code not rejected");

endmodule

// >>> stp_host_model.sv
// host side model: issues apb transfers and self-test commands
// assumes one pclk shared with the slave and a slave that raises pready
`timescale 1ns/1ps
`include "stp_regs.svh"
module stp_host_model
(
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
  end

  // ************************************************************
  // apb transfer
  // ************************************************************
  task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge pclk);
    penable <= 1'b1;
    // registered answer stands a whole cycle: look mid-cycle, act on the next edge
    @(negedge pclk);
    while (pready !== 1'b1)
      @(negedge pclk);
    rdata = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines stop showing the last value
    paddr <= ~addr;
    pwdata <= ~wdata;
  endtask

  task automatic submit(input logic [3:0] code, output logic err);
    logic [31:0] d;
    xfer(1'b1, `STP_OFF_CMD, {28'h0000000, code}, d, err);
  endtask
endmodule

// >>> test_self_test_command_processing.sv
// self-checking bench for the self-test command block
// assumes stp_host_model as the apb host and short test counts
`timescale 1ns/1ps
`include "stp_regs.svh"
module test_self_test_command_processing;
  localparam int unsigned SHORT_N = 200;
  localparam int unsigned EXT_N = 300;
  localparam logic [31:0] CPL_OK = 32'h00010000;
  localparam logic [31:0] CPL_BUSY = 32'h0001011D;
  localparam logic [31:0] CPL_INV = 32'h00010002;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic cpl_post;
  logic subsys_busy_pin;
  int failures = 0;
  int check_count = 0;

  stp_self_test_cmd #(.SHORT_CYCLES(SHORT_N), .EXT_CYCLES(EXT_N)) stp_self_test_cmd_inst
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .cpl_post(cpl_post), .subsys_busy_pin(subsys_busy_pin)
  );

  stp_host_model stp_host_model_inst
  (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // ************************************************************
  // compare and access tasks
  // ************************************************************
  task automatic check32(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic rd(input logic [11:0] addr, input logic [31:0] exp, input logic [31:0] mask);
    logic [31:0] d;
    logic e;
    stp_host_model_inst.xfer(1'b0, addr, 32'h00000000, d, e);
    check32(d & mask, exp, "read data");
    check1(e, 1'b0, "read error");
  endtask

  task automatic wr(input logic [11:0] addr, input logic [31:0] data);
    logic [31:0] d;
    logic e;
    stp_host_model_inst.xfer(1'b1, addr, data, d, e);
    check1(e, 1'b0, "write error");
  endtask

  task automatic cmd(input logic [3:0] code, input logic [31:0] exp);
    logic e;
    int n;
    stp_host_model_inst.submit(code, e);
    check1(e, 1'b0, "submit error");
    n = 0;
    @(negedge pclk);
    while (cpl_post !== 1'b1 && n < 40)
    begin
      @(negedge pclk);
      n++;
    end
    check1(cpl_post, 1'b1, "completion pulse");
    rd(`STP_OFF_CPL, exp, ALL);
  endtask

  task automatic irq_is(input logic exp);
    repeat (3) @(negedge pclk);
    check1(irq, exp, "irq");
  endtask

  task automatic test_end(input string name);
    $display("test %s finished", name);
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    #(20000 * 50);
    failures++;
    $display("unexpected at %0t: watchdog expired", $time);
    test_done();
  end

  // ************************************************************
  // test sequence
  // ************************************************************
  initial
  begin
    logic [31:0] d;
    logic e;
    presetn = 1'b0;
    subsys_busy_pin = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(`STP_OFF_CPL, 32'h00000000, ALL);
    rd(`STP_OFF_LOG, 32'h00000000, ALL);
    rd(`STP_OFF_OPT, 32'h00000000, ALL);
    rd(`STP_OFF_INT_ST, 32'h00000000, ALL);
    rd(`STP_OFF_INT_MASK, 32'h00000000, ALL);
    rd(`STP_OFF_STATE, 32'h00000000, ALL);
    stp_host_model_inst.xfer(1'b0, 12'h01C, 32'h00000000, d, e);
    check32(d, 32'h00000000, "unmapped data");
    check1(e, 1'b1, "unmapped error");
    test_end("reset");
    cmd(`STP_STC_ABORT, CPL_OK);
    rd(`STP_OFF_LOG, 32'h00000000, ALL);
    for (int c = 0; c < 16; c++)
    begin
      if (c == 0 || (c >= 3 && c <= 13))
      begin
        cmd(c[3:0], CPL_INV);
        rd(`STP_OFF_LOG, 32'h00000000, ALL);
      end
    end
    cmd(`STP_STC_VENDOR, CPL_OK);
    rd(`STP_OFF_LOG, 32'h00000000, ALL);
    test_end("idle");
    cmd(`STP_STC_SHORT, CPL_OK);
    rd(`STP_OFF_LOG, 32'h00000001, ALL);
    rd(`STP_OFF_STATE, 32'h00000002, 32'h00000002);
    cmd(`STP_STC_EXT, CPL_BUSY);
    cmd(`STP_STC_SHORT, CPL_BUSY);
    cmd(`STP_STC_VENDOR, CPL_OK);
    rd(`STP_OFF_LOG, 32'h00000001, ALL);
    rd(`STP_OFF_STATE, 32'h00000002, 32'h00000002);
    cmd(`STP_STC_ABORT, CPL_OK);
    rd(`STP_OFF_LOG, 32'h00001100, ALL);
    rd(`STP_OFF_STATE, 32'h00000000, 32'h00000002);
    test_end("abort");
    cmd(`STP_STC_EXT, CPL_OK);
    rd(`STP_OFF_LOG, 32'h00001102, ALL);
    repeat (EXT_N + 20) @(posedge pclk);
    rd(`STP_OFF_LOG, 32'h00002000, ALL);
    rd(`STP_OFF_INT_ST, 32'h00000003, ALL);
    wr(`STP_OFF_INT_MASK, 32'h00000002);
    irq_is(1'b1);
    wr(`STP_OFF_INT_ST, 32'h00000003);
    irq_is(1'b0);
    rd(`STP_OFF_INT_ST, 32'h00000000, ALL);
    cmd(`STP_STC_VENDOR, CPL_OK);
    irq_is(1'b0);
    rd(`STP_OFF_INT_ST, 32'h00000001, ALL);
    wr(`STP_OFF_INT_MASK, 32'h00000003);
    irq_is(1'b1);
    wr(`STP_OFF_INT_ST, 32'h00000001);
    irq_is(1'b0);
    test_end("interrupt");
    wr(`STP_OFF_OPT, 32'h00000001);
    rd(`STP_OFF_OPT, 32'h00000001, ALL);
    subsys_busy_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(`STP_OFF_STATE, 32'h00000004, 32'h00000006);
    cmd(`STP_STC_SHORT, CPL_BUSY);
    cmd(`STP_STC_ABORT, CPL_OK);
    rd(`STP_OFF_LOG, 32'h00002000, ALL);
    wr(`STP_OFF_OPT, 32'h00000000);
    cmd(`STP_STC_SHORT, CPL_OK);
    rd(`STP_OFF_LOG, 32'h00002001, ALL);
    cmd(`STP_STC_ABORT, CPL_OK);
    rd(`STP_OFF_LOG, 32'h00001100, ALL);
    subsys_busy_pin <= 1'b0;
    wr(`STP_OFF_OPT, 32'h00000001);
    repeat (4) @(posedge pclk);
    stp_host_model_inst.submit(`STP_STC_SHORT, e);
    check1(e, 1'b0, "submit error");
    // a second command while the first is still in flight must be refused
    stp_host_model_inst.xfer(1'b1, `STP_OFF_CMD, 32'h00000002, d, e);
    check1(e, 1'b1, "busy command write error");
    while (cpl_post !== 1'b1)
      @(negedge pclk);
    rd(`STP_OFF_CPL, CPL_OK, ALL);
    rd(`STP_OFF_CMD, 32'h00000001, ALL);
    cmd(`STP_STC_ABORT, CPL_OK);
    rd(`STP_OFF_LOG, 32'h00001100, ALL);
    test_end("subsystem");
    test_done();
  end
endmodule
